/* File: mmu_walk.sv */
// Level-one table walker with section translation and permission check
`timescale 1ns/10ps
module mmu_walk
  import mmu_walk_pkg::*;
(
  input  wire logic        clk,            // 125 MHz clock
  input  wire logic        rst_b,          // Synchronous reset, active low
  input  wire logic        base_wr,        // Write strobe for walk_table_base
  input  wire logic [31:0] base_wdata,     // Data for walk_table_base
  input  wire logic        mmu_enable,     // Translation on
  input  wire logic        sys_protect,    // System protection bit
  input  wire logic        rom_protect,    // ROM protection bit
  input  wire logic        cache_enable,   // Cache on
  input  wire logic        wbuf_enable,    // Write buffer on
  input  wire logic [31:0] domain_access,  // Sixteen 2-bit domain settings
  input  wire logic        req_valid,      // Core request valid
  input  core_req_t        req,            // Core request
  output logic             req_ready,      // Walker can take a request
  input  wire logic        tlb_hit,        // Lookup buffer holds the entry
  input  wire logic [31:0] tlb_desc,       // Cached level-one descriptor
  output logic             walk_rd_valid,  // Level-one fetch request
  output logic [29:0]      walk_rd_addr,   // Descriptor word address
  input  wire logic        walk_rd_ack,    // Fetch data returned
  input  wire logic [31:0] walk_rd_data,   // Returned descriptor
  output logic             l2_valid,       // Level-two fetch hand-off
  output logic [31:0]      l2_addr,        // Level-two entry byte address
  output logic [3:0]       l2_domain,      // Domain for the page walk
  input  wire logic        l2_ack,         // Hand-off accepted
  output logic             rsp_valid,      // Translation answer valid
  output xlat_rsp_t        rsp,            // Translation answer
  output logic [31:0]      base_pointer    // Current table base readback
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Domain setting lookup, used in decode for the section domain gate only
  function automatic logic [1:0] domain_field(input logic [31:0] dacr,
                                              input logic [3:0]  dom);
    domain_field = dacr[{dom, 1'b0} +: 2];
  endfunction : domain_field

  function automatic logic [3:0] desc_domain(input logic [31:0] d);
    desc_domain = d[DESC_DOM_LSB +: 4];
  endfunction : desc_domain

  // Attribute flags only pass while their unit is switched on
  function automatic logic gate_flag(input logic flag,
                                     input logic unit_on);
    gate_flag = flag && unit_on;
  endfunction : gate_flag

  // ----------------------------------------------------------------
  // Table base register
  // ----------------------------------------------------------------
  logic [BASE_W-1:0] walk_base_pointer_reg;
  logic [BASE_W-1:0] walk_base_pointer_next;

  // Only bits 31:14 are stored, so the base is always 16KB aligned
  // A write while a fetch is pending changes the fetch address in the next cycle,
  // since the address is formed from the live base; software must not
  // rewrite the base during a walk
  always_comb begin
    walk_base_pointer_next = walk_base_pointer_reg;
    if (base_wr) begin
      walk_base_pointer_next = base_wdata[31:BASE_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      walk_base_pointer_reg <= BASE_RESET;
    end else begin
      walk_base_pointer_reg <= walk_base_pointer_next;
    end
  end

  assign base_pointer = {walk_base_pointer_reg, {BASE_LSB{1'b0}}};

  // ----------------------------------------------------------------
  // Walk state
  // ----------------------------------------------------------------
  // A request moves through the states as follows:
  //   IDLE   takes it; with translation off, or on a lookup-buffer hit,
  //          the table fetch is skipped
  //   FETCH1 holds the level-one fetch until memory acknowledges it
  //   DECODE turns the held descriptor into an answer or a hand-off
  //   LEVEL2 holds the page hand-off until the page walker takes it
  //   RESP   shows the answer for exactly one cycle
  // Control inputs other than mmu_enable are read in DECODE, not when the request is taken, so
  // settings changed mid-walk apply to that walk; this saves a second copy
  // of the domain and protection settings.

  walk_state_t state_reg;
  walk_state_t state_next;
  core_req_t   req_reg;
  core_req_t   req_next;
  logic [31:0] desc_reg;
  logic [31:0] desc_next;
  xlat_rsp_t   rsp_reg;
  xlat_rsp_t   rsp_next;
  logic [31:0] l2_addr_reg;
  logic [31:0] l2_addr_next;
  logic [3:0]  l2_dom_reg;
  logic [3:0]  l2_dom_next;

  // Decode of the held descriptor
  desc_kind_t  kind;
  logic [3:0]  dom;
  logic [1:0]  dom_set;
  logic        perm_ok;
  logic [VA_IDX_W-1:0]  sec_base;   // Section physical base
  logic [L2_BASE_W-1:0] pt_base;    // Page-table base
  logic [1:0]  perm_field;
  logic        cach_flag;
  logic        buf_flag;

  assign kind    = desc_kind_t'(desc_reg[1:0]);
  assign dom     = desc_domain(desc_reg);
  assign dom_set = domain_field(domain_access, dom);

  // Named fields of the held descriptor; bit 9 and bit 4 are never read
  assign sec_base   = desc_reg[31:VA_IDX_LSB];
  assign pt_base    = desc_reg[31:L2_BASE_LSB];
  assign perm_field = desc_reg[DESC_PERM_LSB +: 2];
  assign cach_flag  = desc_reg[DESC_CACH_BIT];
  assign buf_flag   = desc_reg[DESC_BUF_BIT];

  section_perm_check u_perm (
    .perm_code   (perm_field),
    .sys_protect (sys_protect),
    .rom_protect (rom_protect),
    .user        (req_reg.user),
    .write       (req_reg.write),
    .allow       (perm_ok)
  );

  // Domain gate of a section: managers skip the permission field, clients
  // obey it, and no-access or reserved settings abort the access before
  // any memory cycle could start
  logic       sec_fault;
  logic [3:0] sec_code;

  always_comb begin
    sec_fault = 1'b0;
    sec_code  = FAULT_NONE;
    case (dom_set)
      DOM_MANAGER: begin
        sec_fault = 1'b0;
      end
      DOM_CLIENT: begin
        sec_fault = !perm_ok;
        if (!perm_ok) begin
          sec_code = FAULT_PERM_SEC;
        end
      end
      default: begin
        sec_fault = 1'b1;
        sec_code  = FAULT_DOM_SEC;
      end
    endcase
  end

  // Next-state and datapath for the walk
  always_comb begin
    state_next   = state_reg;
    req_next     = req_reg;
    desc_next    = desc_reg;
    rsp_next     = rsp_reg;
    l2_addr_next = l2_addr_reg;
    l2_dom_next  = l2_dom_reg;
    case (state_reg)
      ST_IDLE: begin
        if (req_valid) begin
          req_next = req;
          if (!mmu_enable) begin
            // Untranslated: no walk, no check, no caching attributes
            rsp_next                 = '0;
            rsp_next.paddr           = req.vaddr;
            rsp_next.fault_kind_code = FAULT_NONE;
            state_next               = ST_RESP;
          end else if (tlb_hit) begin
            desc_next  = tlb_desc;
            state_next = ST_DECODE;
          end else begin
            state_next = ST_FETCH1;
          end
        end
      end
      ST_FETCH1: begin
        if (walk_rd_ack) begin
          desc_next  = walk_rd_data;
          state_next = ST_DECODE;
        end
      end
      ST_DECODE: begin
        rsp_next                 = '0;
        rsp_next.domain          = dom;
        rsp_next.fault_kind_code = FAULT_NONE;
        case (kind)
          DESC_SECTION: begin
            rsp_next.paddr           = {sec_base,
                                        req_reg.vaddr[SEC_OFS_W-1:0]};
            rsp_next.fault           = sec_fault;
            rsp_next.fault_kind_code = sec_code;
            if (sec_fault) begin
              rsp_next.paddr = '0;
            end else begin
              rsp_next.cacheable  = gate_flag(cach_flag, cache_enable);
              rsp_next.bufferable = gate_flag(buf_flag, wbuf_enable);
            end
            state_next = ST_RESP;
          end
          DESC_PAGE_TBL: begin
            // Second-level fetch must follow before any translation;
            // the page walker forms that answer, nothing is returned here
            l2_addr_next = {pt_base,
                            req_reg.vaddr[L2_IDX_LSB +: L2_IDX_W], 2'b00};
            l2_dom_next  = dom;
            state_next   = ST_LEVEL2;
          end
          default: begin
            // Invalid and reserved both abort as a section fault
            rsp_next.fault           = 1'b1;
            rsp_next.fault_kind_code = FAULT_XLAT_SEC;
            state_next               = ST_RESP;
          end
        endcase
      end
      ST_LEVEL2: begin
        if (l2_ack) begin
          state_next = ST_IDLE;
        end
      end
      ST_RESP: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Register the walk state
  // Reset clears every held field, so the answer and hand-off outputs
  // read zero until the first request completes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg   <= ST_IDLE;
      req_reg     <= '0;
      desc_reg    <= '0;
      rsp_reg     <= '0;
      l2_addr_reg <= '0;
      l2_dom_reg  <= '0;
    end else begin
      state_reg   <= state_next;
      req_reg     <= req_next;
      desc_reg    <= desc_next;
      rsp_reg     <= rsp_next;
      l2_addr_reg <= l2_addr_next;
      l2_dom_reg  <= l2_dom_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Fetch address is formed from held registers, stable while requested unless the base is rewritten
  // Valid strobes decode the state directly, so each strobe rises in the
  // same cycle its data register is loaded; no extra pipeline stage
  assign walk_rd_addr  = {walk_base_pointer_reg,
                          req_reg.vaddr[31:VA_IDX_LSB]};
  assign walk_rd_valid = (state_reg == ST_FETCH1);
  assign req_ready     = (state_reg == ST_IDLE);
  assign rsp_valid     = (state_reg == ST_RESP);
  assign rsp           = rsp_reg;
  assign l2_valid      = (state_reg == ST_LEVEL2);
  assign l2_addr       = l2_addr_reg;
  assign l2_domain     = l2_dom_reg;

endmodule : mmu_walk

/* File: mmu_walk_pkg.sv */
// Shared constants, encodings and carrier types of the level-one walker
package mmu_walk_pkg;

  // ----------------------------------------------------------------
  // Table base and address layout
  // ----------------------------------------------------------------
  localparam int unsigned BASE_LSB      = 14;     // Base aligned to 16KB
  localparam int unsigned BASE_W        = 18;     // Base bits 31:14
  localparam int unsigned VA_IDX_LSB    = 20;     // Section index bits 31:20
  localparam int unsigned VA_IDX_W      = 12;
  localparam int unsigned WORD_ADDR_W   = 30;     // Descriptor word address
  localparam int unsigned SEC_OFS_W     = 20;     // Offset inside a 1MB section
  localparam int unsigned L2_BASE_LSB   = 10;     // Page-table base bits 31:10
  localparam int unsigned L2_BASE_W     = 22;
  localparam int unsigned L2_IDX_LSB    = 12;     // Page-table index bits 19:12
  localparam int unsigned L2_IDX_W      = 8;
  localparam logic [17:0] BASE_RESET    = 18'h00000;

  // ----------------------------------------------------------------
  // Descriptor fields
  // ----------------------------------------------------------------
  localparam int unsigned DESC_BUF_BIT  = 2;
  localparam int unsigned DESC_CACH_BIT = 3;
  localparam int unsigned DESC_DOM_LSB  = 5;      // Domain bits 8:5
  localparam int unsigned DESC_PERM_LSB = 10;     // Permission bits 11:10

  typedef enum logic [1:0] {
    DESC_INVALID  = 2'h0,
    DESC_PAGE_TBL = 2'h1,
    DESC_SECTION  = 2'h2,
    DESC_RESERVED = 2'h3
  } desc_kind_t;

  // Domain access field settings
  localparam logic [1:0] DOM_NONE    = 2'h0;
  localparam logic [1:0] DOM_CLIENT  = 2'h1;
  localparam logic [1:0] DOM_MANAGER = 2'h3;

  // Permission codes
  localparam logic [1:0] PERM_SYS   = 2'h0;
  localparam logic [1:0] PERM_SUPER = 2'h1;
  localparam logic [1:0] PERM_UREAD = 2'h2;
  localparam logic [1:0] PERM_ALL   = 2'h3;

  // Fault kind codes
  localparam logic [3:0] FAULT_NONE      = 4'h0;
  localparam logic [3:0] FAULT_XLAT_SEC  = 4'h5;
  localparam logic [3:0] FAULT_DOM_SEC   = 4'h9;
  localparam logic [3:0] FAULT_PERM_SEC  = 4'hD;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] vaddr;   // Virtual address from the core
    logic        write;   // 1 = write access
    logic        user;    // 1 = user mode, 0 = supervisor
  } core_req_t;

  typedef struct packed {
    logic [31:0] paddr;            // Physical address, valid when no fault
    logic        cacheable;        // May be placed in the cache
    logic        bufferable;       // Writes go through the write buffer
    logic        fault;            // Access aborted
    logic [3:0]  fault_kind_code;  // Encoded fault kind
    logic [3:0]  domain;           // Domain of the descriptor
  } xlat_rsp_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_FETCH1 = 3'b001,
    ST_DECODE = 3'b010,
    ST_LEVEL2 = 3'b011,
    ST_RESP   = 3'b100
  } walk_state_t;

endpackage : mmu_walk_pkg

/* File: section_perm_check.sv */
// Section permission decode from permission code and protection bits
`timescale 1ns/10ps
module section_perm_check
  import mmu_walk_pkg::*;
(
  input  wire logic [1:0] perm_code,   // Descriptor permission field
  input  wire logic       sys_protect, // System protection control bit
  input  wire logic       rom_protect, // ROM protection control bit
  input  wire logic       user,        // User mode access
  input  wire logic       write,       // Write access
  output logic            allow        // Access permitted
);

  // ----------------------------------------------------------------
  // Permission table
  // ----------------------------------------------------------------
  // Both protection bits set is reserved; failing it keeps behaviour fixed
  always_comb begin
    allow = 1'b0;
    case (perm_code)
      PERM_SYS: begin
        case ({sys_protect, rom_protect})
          2'b00:   allow = 1'b0;
          2'b10:   allow = !user && !write;
          2'b01:   allow = !write;
          default: allow = 1'b0;
        endcase
      end
      PERM_SUPER: allow = !user;
      PERM_UREAD: allow = !user || !write;
      PERM_ALL:   allow = 1'b1;
      default:    allow = 1'b0;
    endcase
  end

endmodule : section_perm_check

/* File: mmu_walk_sva.sv */
// Port assertions of the level-one walker
`timescale 1ns/10ps
module mmu_walk_sva
  import mmu_walk_pkg::*;
(
  input wire logic        clk,           // Clock
  input wire logic        rst_b,         // Reset
  input wire logic        base_wr,       // Base strobe
  input wire logic [31:0] base_wdata,    // Base data
  input wire logic        mmu_enable,    // Translate
  input wire logic        cache_enable,  // Cache on
  input wire logic        wbuf_enable,   // Buffer on
  input wire logic        req_valid,     // Request
  input core_req_t        req,           // Request data
  input wire logic        req_ready,     // Idle
  input wire logic        tlb_hit,       // Hit
  input wire logic        walk_rd_valid, // Fetch
  input wire logic [29:0] walk_rd_addr,  // Fetch address
  input wire logic        walk_rd_ack,   // Fetch done
  input wire logic [31:0] walk_rd_data,  // Descriptor
  input wire logic        l2_valid,      // Hand-off
  input wire logic [31:0] l2_addr,       // L2 address
  input wire logic [3:0]  l2_domain,     // L2 domain
  input wire logic        rsp_valid,     // Answer
  input xlat_rsp_t        rsp,           // Answer data
  input wire logic [31:0] base_pointer   // Base readback
);
  // ----------------------------------------
  // Steps of a walk
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_ack(k);
    walk_rd_valid && walk_rd_ack && walk_rd_data[1:0] == k;
  endsequence
  // Answer latencies are fixed, so each check pins the exact cycle
  chk_walk_on_miss: assert property (s_take ##0 (mmu_enable && !tlb_hit) |=> walk_rd_valid)
    else $error("no fetch after a miss");
  chk_no_walk_hit: assert property (s_take ##0 (tlb_hit || !mmu_enable) |=> !walk_rd_valid [*2])
    else $error("fetch without a miss");
  chk_off_pass: assert property (s_take ##0 !mmu_enable |=>
    rsp_valid && rsp.paddr == $past(req.vaddr) && !rsp.fault)
    else $error("address changed while off");
  chk_base_align: assert property (base_wr |=> base_pointer == {$past(base_wdata[31:14]), 14'h0})
    else $error("table base not aligned");
  chk_fetch_addr: assert property ($rose(walk_rd_valid) |-> walk_rd_addr ==
    {base_pointer[31:14], $past(req.vaddr[31:20])})
    else $error("bad fetch address");
  chk_section_base: assert property (s_ack(2'h2) |-> ##2 rsp_valid &&
    (rsp.fault || rsp.paddr[31:20] == $past(walk_rd_data[31:20], 2)))
    else $error("bad section base");
  chk_page_handoff: assert property (s_ack(2'h1) |-> ##2 l2_valid && !rsp_valid &&
    l2_addr[31:10] == $past(walk_rd_data[31:10], 2) && l2_domain == $past(walk_rd_data[8:5], 2))
    else $error("bad level-two hand-off");
  chk_invalid_desc: assert property (s_ack(2'h0) |-> ##2 rsp_valid && rsp.fault &&
    rsp.fault_kind_code == FAULT_XLAT_SEC)
    else $error("invalid descriptor not faulted");
  chk_fault_quiet: assert property (rsp_valid && rsp.fault |->
    rsp.paddr == 32'h0 && !rsp.cacheable && !rsp.bufferable)
    else $error("faulting answer carries an address");
  chk_flag_gate: assert property (rsp_valid |->
    (!rsp.cacheable || $past(cache_enable)) && (!rsp.bufferable || $past(wbuf_enable)))
    else $error("flag set while disabled");
  chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid && req_ready)
    else $error("answer not a single pulse");
endmodule : mmu_walk_sva

bind mmu_walk mmu_walk_sva i_sva (
  .clk(clk), .rst_b(rst_b), .base_wr(base_wr), .base_wdata(base_wdata),
  .mmu_enable(mmu_enable), .cache_enable(cache_enable), .wbuf_enable(wbuf_enable),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .tlb_hit(tlb_hit),
  .walk_rd_valid(walk_rd_valid), .walk_rd_addr(walk_rd_addr), .walk_rd_ack(walk_rd_ack),
  .walk_rd_data(walk_rd_data), .l2_valid(l2_valid), .l2_addr(l2_addr),
  .l2_domain(l2_domain), .rsp_valid(rsp_valid), .rsp(rsp), .base_pointer(base_pointer)
);

/* File: mem_table.sv */
// Table memory model answering descriptor fetches and hand-offs
`timescale 1ns/10ps
module mem_table (
  input  wire logic        clk,           // Clock
  input  wire logic        rst_b,         // Reset
  input  wire logic [1:0]  lat,           // Wait cycles
  input  wire logic        walk_rd_valid, // Fetch
  input  wire logic [29:0] walk_rd_addr,  // Word address
  output logic             walk_rd_ack,   // Data strobe
  output logic [31:0]      walk_rd_data,  // Descriptor
  input  wire logic        l2_valid,      // Hand-off
  output logic             l2_ack         // Hand-off taken
);
  logic [31:0] mem [logic [29:0]];
  logic [1:0]  cnt;
  // ----------------------------------------
  // Answer after lat cycles
  // ----------------------------------------
  // Data toggles between answers so a sample an odd number of cycles late never sees a stale word
  always @(posedge clk) begin
    walk_rd_ack  <= 1'b0;
    l2_ack       <= 1'b0;
    walk_rd_data <= ~walk_rd_data;
    if (!rst_b) begin
      cnt          <= 2'h0;
      walk_rd_data <= 32'h5A5A5A5A;
    end else if ((walk_rd_valid && !walk_rd_ack) || (l2_valid && !l2_ack)) begin
      if (cnt < lat) begin
        cnt <= cnt + 2'h1;
      end else begin
        cnt          <= 2'h0;
        walk_rd_ack  <= walk_rd_valid;
        l2_ack       <= l2_valid;
        walk_rd_data <= mem.exists(walk_rd_addr) ? mem[walk_rd_addr] : 32'h0;
      end
    end
  end
endmodule : mem_table

/* File: tb_top.sv */
// Self-checking testbench of the level-one walker
`timescale 1ns/10ps
module tb_top;
  import mmu_walk_pkg::*;
  typedef struct packed {
    logic        off; // Only address and flags count
    logic        pg;  // Hand-off expected
    xlat_rsp_t   r;
    logic [31:0] la;
  } exp_t;
  logic        clk, rst_b, base_wr, mmu_enable, sys_protect, rom_protect;
  logic        cache_enable, wbuf_enable, req_valid, req_ready, tlb_hit;
  logic        walk_rd_valid, walk_rd_ack, l2_valid, l2_ack, rsp_valid;
  logic [31:0] base_wdata, domain_access, tlb_desc, walk_rd_data, l2_addr;
  logic [31:0] base_pointer, base, da;
  logic [29:0] walk_rd_addr;
  logic [3:0]  l2_domain, dm;
  logic [1:0]  lat;
  core_req_t   req;
  xlat_rsp_t   rsp;
  exp_t        q[$];
  exp_t        e;
  int          n_errors, cmp_count, seed;

  mmu_walk  i_dut (
    .clk(clk), .rst_b(rst_b), .base_wr(base_wr), .base_wdata(base_wdata),
    .mmu_enable(mmu_enable), .sys_protect(sys_protect), .rom_protect(rom_protect),
    .cache_enable(cache_enable), .wbuf_enable(wbuf_enable), .domain_access(domain_access),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .tlb_hit(tlb_hit),
    .tlb_desc(tlb_desc), .walk_rd_valid(walk_rd_valid), .walk_rd_addr(walk_rd_addr),
    .walk_rd_ack(walk_rd_ack), .walk_rd_data(walk_rd_data), .l2_valid(l2_valid),
    .l2_addr(l2_addr), .l2_domain(l2_domain), .l2_ack(l2_ack), .rsp_valid(rsp_valid),
    .rsp(rsp), .base_pointer(base_pointer)
  );
  mem_table i_mem (
    .clk(clk), .rst_b(rst_b), .lat(lat), .walk_rd_valid(walk_rd_valid),
    .walk_rd_addr(walk_rd_addr), .walk_rd_ack(walk_rd_ack), .walk_rd_data(walk_rd_data),
    .l2_valid(l2_valid), .l2_ack(l2_ack)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(string what, logic [63:0] x, logic [63:0] g);
    cmp_count++;
    if (x !== g) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, x, g);
    end
  endtask : check

  // ----------------------------------------
  // Expected answer, worked out from the rules
  // ----------------------------------------
  function automatic exp_t predict(core_req_t a, logic [31:0] d);
    exp_t       x;
    logic [1:0] ds;
    logic       ok;
    x = '0;
    ds = domain_access[2*d[8:5] +: 2];
    x.off = !mmu_enable;
    x.pg = mmu_enable && d[1:0] == 2'h1;
    x.la = {d[31:10], a.vaddr[19:12], 2'h0};
    x.r.domain = d[8:5];
    case (d[11:10])
      2'h0: ok = (sys_protect ^ rom_protect) && !a.write && !(a.user && sys_protect);
      2'h1: ok = !a.user;
      2'h2: ok = !(a.user && a.write);
      default: ok = 1'b1;
    endcase
    if (!mmu_enable) x.r.paddr = a.vaddr;
    else if (d[1:0] == 2'h0 || d[1:0] == 2'h3) {x.r.fault, x.r.fault_kind_code} = {1'b1, FAULT_XLAT_SEC};
    else if (ds == DOM_NONE || ds == 2'h2) {x.r.fault, x.r.fault_kind_code} = {1'b1, FAULT_DOM_SEC};
    else if (ds == DOM_CLIENT && !ok) {x.r.fault, x.r.fault_kind_code} = {1'b1, FAULT_PERM_SEC};
    else begin
      x.r.paddr = {d[31:20], a.vaddr[19:0]};
      x.r.cacheable = d[3] && cache_enable;
      x.r.bufferable = d[2] && wbuf_enable;
    end
    return x;
  endfunction : predict

  // Request one translation; the descriptor sits both in memory and the lookup buffer
  task automatic xfer(logic [1:0] ty, logic [1:0] ap, logic [3:0] dom, logic [1:0] uw,
                      logic hit);
    core_req_t   a;
    logic [31:0] d;
    int          k;
    a.vaddr = $random(seed);
    a.user = uw[1];
    a.write = uw[0];
    d = $random(seed);
    if (ty == 2'h2) d[19:12] = 8'h00;
    if (ty == 2'h1) d[3:2] = 2'h0;
    d[11:0] = {ap, 1'b0, dom, 1'b1, d[3:2], ty};
    i_mem.mem[{base[31:14], a.vaddr[31:20]}] = d;
    req_valid <= 1'b1;
    req <= a;
    tlb_hit <= hit;
    tlb_desc <= d;
    lat <= 2'($random(seed));
    @(negedge clk);
    while (!req_ready) @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    q.push_back(predict(a, d));
    for (k = 0; k < 20 && !req_ready; k++) @(negedge clk);
  endtask : xfer

  // Compares each answer or hand-off with the oldest note
  always @(posedge clk) begin
    if (rst_b && (rsp_valid || (l2_valid && l2_ack))) begin
      e = q.pop_front();
      check("handoff", e.pg, l2_valid);
      if (e.pg) check("l2", {e.r.domain, e.la}, {l2_domain, l2_addr});
      else if (e.off) check("paddr", {e.r.paddr, 3'h0},
                            {rsp.paddr, rsp.cacheable, rsp.bufferable, rsp.fault});
      else check("rsp", e.r, rsp);
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("MISMATCH watchdog expected done seen hung");
    conclude();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 70319;
    {rst_b, base_wr, mmu_enable, sys_protect, rom_protect, cache_enable} = '0;
    {wbuf_enable, req_valid, tlb_hit, lat, n_errors, cmp_count} = '0;
    {base_wdata, domain_access, tlb_desc, base, req} = '0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    check("base_pointer", 0, base_pointer);
    @(posedge clk);
    base = $random(seed) | 32'h3FFF;
    base_wr <= 1'b1;
    base_wdata <= base;
    @(posedge clk);
    base_wr <= 1'b0;
    @(negedge clk);
    check("base_pointer", {base[31:14], 14'h0}, base_pointer);
    $display("test base done");
    // Every code, protection pair, mode and domain setting
    for (int i = 0; i < 256; i++) begin
      @(posedge clk);
      mmu_enable <= 1'b1;
      {sys_protect, rom_protect} <= i[3:2];
      {cache_enable, wbuf_enable} <= 2'($random(seed));
      dm = 4'($random(seed));
      da = $random(seed);
      da[2*dm +: 2] = i[7:6];
      domain_access <= da;
      xfer(2'h2, i[1:0], dm, i[5:4], 1'($random(seed)));
    end
    $display("test permissions done");
    // Each descriptor kind, translation on and off, walked and from the lookup buffer
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      mmu_enable <= i[2];
      domain_access <= 32'h55555555;
      xfer(i[1:0], 2'h3, 4'h3, 2'h3, i[3]);
    end
    $display("test descriptor kinds done");
    repeat (5) @(posedge clk);
    check("pending", 0, q.size());
    conclude();
  end
endmodule : tb_top
